/* File: design/atten_shifter.sv */
// Serial word engine: drives mode, clock, data and latch strobe pins.
// Assumes orders come from logic on pclk; start is a one-cycle pulse.
`timescale 1ns/1ps
module atten_shifter
	import atten_pkg::*;
#(
	parameter int GAP_CYC = SWITCH_GAP_CYC
) (
	input  wire logic         pclk,     // System clock
	input  wire logic         presetn,  // Async reset, low
	input  wire shift_order_t order,    // Word request
	output atten_pins_t       pins,     // Pins to attenuator
	output logic              busy,     // Word in progress
	output logic [5:0]        applied   // Last word latched
);
	typedef enum {S_IDLE, S_MODE, S_LOW, S_HIGH, S_LSETUP, S_LATCH,
		S_LHOLD, S_GAP} state_t;

	state_t      state, next_state;
	atten_pins_t next_pins;
	logic [5:0]  sreg, next_sreg;
	logic [2:0]  bitn, next_bitn;
	logic [15:0] cnt, next_cnt;
	logic        direct, next_direct;
	logic [5:0]  next_applied;
	// Applied word is held by a snapshot since order.code may move
	logic [5:0]  word_hold, next_word_hold;
	logic        next_busy;

	// --------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------
	always_comb begin
		next_state   = state;
		next_pins    = pins;
		next_sreg    = sreg;
		next_bitn    = bitn;
		next_cnt     = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
		next_direct  = direct;
		next_applied = applied;
		next_word_hold = word_hold;
		case (state)
			S_IDLE: begin
				if (order.start) begin
					next_pins.interface_select = order.serial;
					next_direct = order.direct;
					next_sreg   = order.code;
					next_word_hold = order.code;
					next_bitn   = 3'(WORD_BITS);
					next_pins.latch_strobe = order.serial & order.direct;
					if (!order.serial) begin
						next_state = S_IDLE;
					end else begin
						next_cnt = 16'(MODE_SETUP_CYC);
						next_state = S_MODE;
					end
				end
			end
			S_MODE: begin
				if (cnt == 16'h0000) begin
					next_state = S_LOW;
				end
			end
			S_LOW: begin
				next_pins.serial_data  = sreg[5];
				next_pins.serial_clock = 1'b0;
				next_cnt   = 16'(SCLK_HALF_CYC);
				next_state = S_HIGH;
			end
			S_HIGH: begin
				if (cnt == 16'h0000) begin
					next_pins.serial_clock = 1'b1;
					next_sreg = {sreg[4:0], 1'b0};
					next_bitn = bitn - 3'h1;
					next_cnt  = 16'(LATCH_SETUP_CYC);
					next_state = (bitn == 3'h1) ? S_LSETUP : S_LOW;
				end
			end
			S_LSETUP: begin
				if (cnt == 16'h0000) begin
					next_pins.serial_clock = 1'b0;
					if (direct) begin
						next_applied = word_hold;
						next_cnt   = 16'(GAP_CYC);
						next_state = S_GAP;
					end else begin
						next_pins.latch_strobe = 1'b1;
						next_cnt   = 16'(LATCH_WIDTH_CYC);
						next_state = S_LATCH;
					end
				end
			end
			S_LATCH: begin
				if (cnt == 16'h0000) begin
					next_pins.latch_strobe = 1'b0;
					next_applied = word_hold;
					next_cnt   = 16'(LATCH_HOLD_CYC);
					next_state = S_LHOLD;
				end
			end
			S_LHOLD: begin
				if (cnt == 16'h0000) begin
					next_cnt   = 16'(GAP_CYC);
					next_state = S_GAP;
				end
			end
			default: begin
				if (cnt == 16'h0000) begin
					next_state = S_IDLE;
				end
			end
		endcase
		next_busy = (next_state != S_IDLE);
	end

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= S_IDLE;
			pins    <= '{interface_select: 1'b1, latch_strobe: 1'b0,
				serial_clock: 1'b0, serial_data: 1'b0};
			sreg    <= 6'h00;
			bitn    <= 3'h0;
			cnt     <= 16'h0000;
			direct  <= 1'b0;
			applied <= POWERUP_CODE;
			busy    <= 1'b0;
			word_hold <= POWERUP_CODE;
		end else begin
			state   <= next_state;
			pins    <= next_pins;
			sreg    <= next_sreg;
			bitn    <= next_bitn;
			cnt     <= next_cnt;
			direct  <= next_direct;
			applied <= next_applied;
			busy    <= next_busy;
			word_hold <= next_word_hold;
		end
	end
endmodule

/* File: design/atten_pkg.sv */
// Constants and types for the serial step attenuator host controller.
// Assumes a 10 MHz pclk; all link timing is counted in pclk cycles.
// Function
// - Six-bit word is sent most significant bit (16 dB) first.
// - Host holds latch strobe low while all six bits shift; in direct mode the host holds it high instead.
// - Host returns latch strobe low after latching; later shifts stay hidden. In direct mode the host leaves it high after the word.
// - Wait at least 100 ns from mode rising to first clock rise.
// - Latch rises at least 10 ns after last clock rise less half period.
// - Latch pulse at least 10 ns; 10 ns after fall before next clock.
// - Do not change attenuation faster than about 25 kHz.
package atten_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 100;
	localparam int MODE_TO_CLOCK_SETUP_NS = 100;
	localparam int LATCH_SETUP_NS      = 10;
	localparam int LATCH_WIDTH_NS      = 10;
	localparam int LATCH_HOLD_NS       = 10;
	localparam int MAX_SWITCH_RATE_HZ  = 25000;
	localparam int CLK_FREQ_HZ         = 1000000000 / CLK_PERIOD_NS;

	// Least times round up, never below one cycle
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int MODE_SETUP_CYC = ns_to_cycles(MODE_TO_CLOCK_SETUP_NS);
	localparam int LATCH_SETUP_CYC = ns_to_cycles(LATCH_SETUP_NS);
	localparam int LATCH_WIDTH_CYC = ns_to_cycles(LATCH_WIDTH_NS);
	localparam int LATCH_HOLD_CYC  = ns_to_cycles(LATCH_HOLD_NS);
	// Least spacing after a word in pclk cycles; a parameter default
	localparam int SWITCH_GAP_CYC  = CLK_FREQ_HZ / MAX_SWITCH_RATE_HZ;
	// Half period of the serial clock in pclk cycles
	localparam int SCLK_HALF_CYC   = 1;

	// ------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------
	localparam int WORD_BITS = 6;
	localparam logic [5:0] POWERUP_CODE = 6'h3F;

	// ------------------------------------------------------------
	// APB register map of the controller
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_WORD   = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam int CTRL_SERIAL_BIT = 0;
	localparam int CTRL_DIRECT_BIT = 1;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_MODE_BIT   = 1;
	localparam int STAT_CODE_LSB   = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

	// Pins toward the attenuator
	typedef struct packed {
		logic interface_select;
		logic latch_strobe;
		logic serial_clock;
		logic serial_data;
	} atten_pins_t;

	// Order handed from the register file to the shifter
	typedef struct packed {
		logic       start;
		logic       serial;
		logic       direct;
		logic [5:0] code;
	} shift_order_t;

endpackage

/* File: design/atten_host.sv */
// Host controller top: APB registers steer the attenuator word engine.
// Assumes APB master on pclk; attenuator pins go straight to the part.
`timescale 1ns/1ps
module atten_host
	import atten_pkg::*;
#(
	parameter int GAP_CYC = SWITCH_GAP_CYC
) (
	input  wire logic        pclk,             // System clock
	input  wire logic        presetn,          // Async reset, low
	input  wire logic        psel,             // APB select
	input  wire logic        penable,          // APB enable
	input  wire logic        pwrite,           // APB write
	input  wire logic [11:0] paddr,            // APB address
	input  wire logic [31:0] pwdata,           // APB write data
	output logic      [31:0] prdata,           // APB read data
	output logic             pready,           // APB ready
	output logic             pslverr,          // APB error
	output logic             interface_select, // Mode pin
	output logic             latch_strobe,     // Latch pin
	output logic             serial_clock,     // Serial clock pin
	output logic             serial_data       // Serial data pin
);
	// --------------------------------------------------------
	// Register file
	// --------------------------------------------------------
	logic [31:0]  ctrl, next_ctrl;
	logic [31:0]  next_prdata;
	logic         next_pslverr;
	shift_order_t order, next_order;
	atten_pins_t  pins;
	logic         busy;
	logic [5:0]   applied;

	// Write to word register launches a transfer; ignored while busy
	always_comb begin
		next_ctrl    = ctrl;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		next_order   = order;
		next_order.start = 1'b0;
		if (psel && !penable) begin
			if (paddr == REG_CTRL) begin
				if (pwrite) next_ctrl = pwdata;
				next_prdata = ctrl;
			end else if (paddr == REG_WORD) begin
				if (pwrite && !busy && !order.start) begin
					next_order.start  = 1'b1;
					next_order.serial = ctrl[CTRL_SERIAL_BIT];
					next_order.direct = ctrl[CTRL_DIRECT_BIT];
					next_order.code   = pwdata[5:0];
				end
				next_prdata = {26'h0, order.code};
			end else if (paddr == REG_STATUS) begin
				next_prdata = 32'h0;
				next_prdata[STAT_BUSY_BIT] = busy | order.start;
				next_prdata[STAT_MODE_BIT] = pins.interface_select;
				next_prdata[STAT_CODE_LSB +: 6] = applied;
			end else begin
				next_prdata  = 32'h0;
				next_pslverr = 1'b1;
			end
		end
	end

	// Setup cycle decodes; access cycle answers with pready high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl    <= CTRL_RESET;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
			pready  <= 1'b0;
			order   <= '{start: 1'b0, serial: 1'b1, direct: 1'b0,
				code: POWERUP_CODE};
		end else begin
			ctrl    <= next_ctrl;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
			pready  <= psel && !penable;
			order   <= next_order;
		end
	end

	atten_shifter #(
		.GAP_CYC (GAP_CYC)
	) u_shift (
		.pclk    (pclk),
		.presetn (presetn),
		.order   (order),
		.pins    (pins),
		.busy    (busy),
		.applied (applied)
	);

	// Pins come from shifter flip-flops
	assign interface_select = pins.interface_select;
	assign latch_strobe     = pins.latch_strobe;
	assign serial_clock     = pins.serial_clock;
	assign serial_data      = pins.serial_data;
endmodule

/* File: sim/atten_host_properties.sv */
// Checker for the link pins and APB answer timing of the host controller.
// Assumes it is bound to atten_host and that everything runs on pclk.
`timescale 1ns/1ps
module atten_host_properties (
	input wire logic pclk,             // Clock
	input wire logic presetn,          // Reset, low
	input wire logic psel,             // APB select
	input wire logic penable,          // APB enable
	input wire logic pready,           // APB ready
	input wire logic pslverr,          // APB error
	input wire logic interface_select, // Mode pin
	input wire logic latch_strobe,     // Latch pin
	input wire logic serial_clock,     // Serial clock
	input wire logic serial_data       // Serial data
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Clock kept low while the device settles into serial mode
	sequence clock_quiet;
		!serial_clock [*2];
	endsequence
	AST_APB_ANSWER: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	AST_APB_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_QUAL: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_MODE_SETUP: assert property (
		$rose(interface_select) |-> clock_quiet)
		else $error("clock rose too soon after mode change");
	AST_PARALLEL_IDLE: assert property (
		!interface_select |-> !serial_clock)
		else $error("clock toggled in parallel mode");
	AST_DATA_SETUP: assert property (
		$rose(serial_clock) |-> $stable(serial_data))
		else $error("data moved at clock rise");
	AST_LATCH_AFTER_CLK: assert property (
		$rose(latch_strobe) |-> !serial_clock)
		else $error("strobe rose with clock high");
	AST_LATCH_HOLD: assert property (
		$fell(latch_strobe) |-> !serial_clock)
		else $error("clock high at strobe fall");
	AST_STROBE_PULSE: assert property (
		$rose(latch_strobe) && $past(serial_clock)
		|=> latch_strobe ##[1:3] !latch_strobe)
		else $error("latch pulse not returned low");
endmodule
bind atten_host atten_host_properties chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.interface_select(interface_select), .latch_strobe(latch_strobe),
	.serial_clock(serial_clock), .serial_data(serial_data));

/* File: sim/atten_model.sv */
// Behavioural step attenuator: shift register and active register.
// Assumes pins come straight from the host; a mode pin left open reads high.
`timescale 1ns/1ps
module atten_model (
	input  wire logic  interface_select, // Mode pin
	input  wire logic  latch_strobe,     // Latch pin
	input  wire logic  serial_clock,     // Serial clock
	input  wire logic  serial_data,      // Serial data
	output logic [5:0] active,           // Applied code
	output logic [15:0] tenths,          // Loss in 0.1 dB
	output int         changes           // Active updates
);
	logic [5:0] shift;
	wire serial_mode = (interface_select !== 1'b0);
	initial begin
		shift = 6'h3F;
		active = 6'h3F;
		changes = 0;
	end
	always @(posedge serial_clock) if (serial_mode) begin
		shift <= {shift[4:0], serial_data};
		if (latch_strobe) active <= {shift[4:0], serial_data};
	end
	always @(posedge latch_strobe) if (serial_mode) active <= shift;
	always @(active) changes = changes + 1;
	assign tenths = 16'(active) * 16'h0005;
endmodule

/* File: sim/tb_top.sv */
// Testbench: APB orders to the host controller, judged at a device model.
// Assumes 10 MHz pclk and a switching gap shortened to two cycles.
`timescale 1ns/1ps
module tb_top;
	import atten_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, e, sel, stb, sck, sdo;
	logic [5:0]  active;
	logic [15:0] tenths;
	int          changes, fails = 0, comparisons = 0;
	always #50 pclk = ~pclk;
	atten_host #(.GAP_CYC(2)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .interface_select(sel), .latch_strobe(stb),
		.serial_clock(sck), .serial_data(sdo));
	atten_model model (.interface_select(sel), .latch_strobe(stb),
		.serial_clock(sck), .serial_data(sdo), .active(active),
		.tenths(tenths), .changes(changes));
	task automatic chk(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; waits on pready, the watchdog cuts a hang
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle();
		repeat (40) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (r[STAT_BUSY_BIT] === 1'b0) return;
		end
	endtask
	task automatic send(input logic [5:0] code, input logic [5:0] want);
		apb(1'b1, REG_WORD, 32'(code));
		settle();
		chk("active", 32'(want), 32'(active));
		chk("status code", 32'(want), 32'(r[13:8]));
	endtask
	task automatic t_reset();
		chk("powerup", 32'h3F, 32'(active));
		chk("tenths", 32'h13B, 32'(tenths));
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", CTRL_RESET, r);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h3F02, r);
	endtask
	task automatic t_words();
		logic [5:0] codes [9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08,
			6'h10, 6'h20, 6'h3F, 6'h2A};
		logic [5:0] prev;
		int c0;
		prev = active;
		foreach (codes[i]) begin
			c0 = changes;
			send(codes[i], codes[i]);
			chk("changes", 32'(codes[i] != prev), 32'(changes - c0));
			chk("tenths", 32'(codes[i]) * 32'h5, 32'(tenths));
			prev = codes[i];
		end
	endtask
	// Second word while busy is dropped; unmapped address errors
	task automatic t_refuse();
		apb(1'b1, REG_WORD, 32'h15);
		send(6'h2A, 6'h15);
		apb(1'b0, REG_WORD, 32'h0);
		chk("word", 32'h15, r);
		apb(1'b0, 12'h00C, 32'h0);
		chk("slverr", 32'h1, 32'(e));
	endtask
	task automatic t_parallel();
		apb(1'b1, REG_CTRL, 32'h0);
		send(6'h07, 6'h15);
		chk("select pin", 32'h0, 32'(sel));
		apb(1'b1, REG_CTRL, 32'h1);
		send(6'h07, 6'h07);
	endtask
	task automatic t_direct();
		apb(1'b1, REG_CTRL, 32'h3);
		send(6'h33, 6'h33);
		apb(1'b1, REG_CTRL, 32'h1);
	endtask
	task automatic results();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_words();
		t_refuse();
		t_parallel();
		t_direct();
		results();
	end
	// Whole run needs under a thousand cycles; this margin is generous
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		results();
	end
endmodule
